// *** common/mpwm_regs.vh ***
// Register offsets, field positions, reset values and mode codes of the PWM core.
`ifndef MPWM_REGS_VH
`define MPWM_REGS_VH

// =====================================================================
// Register byte offsets
`define MPWM_OFF_CTRL 8'h00
`define MPWM_OFF_CNT 8'h04
`define MPWM_OFF_PER 8'h08
`define MPWM_OFF_OC1 8'h0C
`define MPWM_OFF_OC2 8'h10
`define MPWM_OFF_DUTY1 8'h14
`define MPWM_OFF_DUTY2 8'h18
`define MPWM_OFF_DUTY3 8'h1C
`define MPWM_OFF_DUTY4 8'h20

// =====================================================================
// Time-base control and counter register fields
`define MPWM_CTRL_EN 15
`define MPWM_CTRL_OPS_HI 7
`define MPWM_CTRL_OPS_LO 4
`define MPWM_CTRL_CKPS_HI 3
`define MPWM_CTRL_CKPS_LO 2
`define MPWM_CTRL_MOD_HI 1
`define MPWM_CTRL_MOD_LO 0
`define MPWM_CNT_DIR 15

// Output control register one: pair-mode bits 3:0.
`define MPWM_OC1_PMOD_LO 0
// Output control register two fields.
`define MPWM_OC2_UPDATE_DISABLE_BIT 0
`define MPWM_OC2_IUE 2

// =====================================================================
// Time-base modes
`define MPWM_MODE_FREE 2'h0
`define MPWM_MODE_SINGLE 2'h1
`define MPWM_MODE_UPDN 2'h2
`define MPWM_MODE_DBL 2'h3

// Prescale selections
`define MPWM_CKPS_1 2'h0
`define MPWM_CKPS_4 2'h1
`define MPWM_CKPS_16 2'h2
`define MPWM_CKPS_64 2'h3

// =====================================================================
// Reset values
`define MPWM_RST_CTRL 16'h0000
`define MPWM_RST_PER 15'h0000
`define MPWM_RST_DUTY 16'h0000
`define MPWM_RST_OC1 4'h0
`define MPWM_RST_OC2 3'h0

`endif

// *** rtl/mpwm_core.v ***
// Motor PWM time base, duty comparators and complementary pairs on AHB-Lite.
`include "mpwm_regs.vh"

// What this block does
// RULE1: Up/down modes count up to period then down; direction flag reads 1 descending.
// RULE2: Mode 10 raises an event at zero turning upward, divided by postscaler.
// RULE3: Mode 11 raises events at zero and at period match; postscaler ignored.
// RULE4: Software must never program period value 1.
// RULE5: Counter clock passes a prescaler selectable 1, 4, 16 or 64.
// RULE6: Counter or control writes and reset clear prescaler; control write keeps counter.
// RULE7: Period events pass a 4-bit postscaler dividing 1 to 16; code sends mode 01 period-match events out directly, not postscaled.
// RULE8: Counter or control writes and reset clear the postscaler counter.
// RULE9: Period is double-buffered; loads at period reset or at zero in up/down.
// RULE10: Period buffer loads into active period whenever the time base is off.
// RULE11: Edge-aligned outputs go active at zero and inactive at duty match.
// RULE12: Edge-aligned: duty zero never active; duty above period always active.
// RULE13: Center-aligned: active on match counting down, inactive on match counting up.
// RULE14: Center-aligned: duty zero never active; duty equal period always active.
// RULE15: Four 16-bit duties; bit zero adds a half-step edge at period start; code gives an odd duty the edge of the next even duty.
// RULE16: Each duty has a software buffer and a separate active compare value.
// RULE17: Edge-aligned duties load at period reset, or when off with update enabled.
// RULE18: Up/down duties load at zero, also at period match in double mode.
// RULE19: With immediate update set, duty writes reach the active value at once.
// RULE20: Immediate update shortens, lengthens or starts the pulse against the counter.
// RULE21: Comparator n drives pair n; low output is complement of high.
// RULE22: Pair-mode bits select complementary when clear and reset clear.
// RULE23: Mode 00 free-running, mode 01 single-shot clears enable after one period.
// RULE24: Direction flag is counter register bit 15; count in bits 14:0.
// RULE25: Period zero stops counting and events; period buffer then loads only when off.
// RULE26: Time-base events leave as single-cycle pulses after postscaling.
module mpwm_core #(
    parameter NUM_PAIRS = 4,
    parameter CNT_W = 15,
    parameter DUTY_W = 16
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [NUM_PAIRS-1:0] pair_high_output_o,
    output reg [NUM_PAIRS-1:0] pair_low_output_o,
    output reg [NUM_PAIRS-1:0] pair_mode_bit_o,
    output reg timebase_event_o
);

// =====================================================================
// Registers
reg timebase_enable_bit_r;
reg [1:0] timebase_mode_field_r;
reg [1:0] input_prescale_select_r;
reg [3:0] event_postscale_select_r;
reg [CNT_W-1:0] timebase_counter_r;
reg count_direction_flag_r;
reg [CNT_W-1:0] period_buf_r;
reg [CNT_W-1:0] period_value_r;
reg [NUM_PAIRS-1:0] pair_mode_r;
reg update_disable_bit_r;
reg immediate_update_bit_r;
reg [DUTY_W-1:0] duty_buf_r [0:NUM_PAIRS-1];
reg [DUTY_W-1:0] duty_act_r [0:NUM_PAIRS-1];
reg [NUM_PAIRS-1:0] cmp_r;
reg [5:0] pre_cnt_r;
reg [3:0] post_cnt_r;

// Latched AHB address phase.
reg wr_pend_r;
reg [7:0] wr_addr_r;

// =====================================================================
// Bus decode
wire addr_phase = hsel_i && hready_i && htrans_i[1];
wire wr_ctrl = wr_pend_r && (wr_addr_r == `MPWM_OFF_CTRL);
wire wr_cnt = wr_pend_r && (wr_addr_r == `MPWM_OFF_CNT);
wire wr_per = wr_pend_r && (wr_addr_r == `MPWM_OFF_PER);
wire wr_oc1 = wr_pend_r && (wr_addr_r == `MPWM_OFF_OC1);
wire wr_oc2 = wr_pend_r && (wr_addr_r == `MPWM_OFF_OC2);

// =====================================================================
// Prescaler: one-cycle tick at the selected rate.
reg [5:0] pre_max;
always @*
begin
    case (input_prescale_select_r)
        `MPWM_CKPS_1: pre_max = 6'h00;
        `MPWM_CKPS_4: pre_max = 6'h03;
        `MPWM_CKPS_16: pre_max = 6'h0F;
        `MPWM_CKPS_64: pre_max = 6'h3F;
        default: pre_max = 6'h00;
    endcase
end
// RULE5
wire tick = timebase_enable_bit_r && (pre_cnt_r == pre_max);

// =====================================================================
// Time-base state
wire updn = timebase_mode_field_r[1];
wire per_zero = (period_value_r == {CNT_W{1'b0}});
wire at_zero = (timebase_counter_r == {CNT_W{1'b0}});
wire at_per = (timebase_counter_r == period_value_r);
// Counting is frozen with a zero period.
wire run = tick && !per_zero; // RULE25
wire per_match = run && at_per;
// Zero turn-around in up/down modes: a tick at zero always turns the count
// upward, whatever the direction flag still shows before that tick.
wire zero_turn = run && updn && at_zero;
// Edge-aligned period boundary: counter resets after a match.
wire edge_reset = per_match && !updn;
wire dbl_match = per_match && (timebase_mode_field_r == `MPWM_MODE_DBL);

// Raw events before postscaling.
reg raw_post_evt;
reg direct_evt;
always @*
begin
    raw_post_evt = 1'b0;
    direct_evt = 1'b0;
    case (timebase_mode_field_r)
        `MPWM_MODE_FREE: raw_post_evt = per_match;
        `MPWM_MODE_SINGLE: direct_evt = per_match;
        `MPWM_MODE_UPDN: raw_post_evt = zero_turn; // RULE2
        `MPWM_MODE_DBL: direct_evt = zero_turn || per_match; // RULE3
        default: direct_evt = 1'b0;
    endcase
end
// RULE7
wire post_hit = raw_post_evt && (post_cnt_r == event_postscale_select_r);

// Buffer transfer moments.
wire per_load = !timebase_enable_bit_r
    || (!per_zero && (edge_reset || (updn && run && at_zero))); // RULE9 RULE10
wire duty_load = updn
    ? (!timebase_enable_bit_r || zero_turn || dbl_match) // RULE18
    : (edge_reset || (!timebase_enable_bit_r && !update_disable_bit_r)); // RULE17

// =====================================================================
// Control, time base, prescaler and postscaler
always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        wr_pend_r <= 1'b0;
        wr_addr_r <= 8'h00;
        timebase_enable_bit_r <= 1'b0;
        timebase_mode_field_r <= 2'h0;
        input_prescale_select_r <= 2'h0;
        event_postscale_select_r <= 4'h0;
        timebase_counter_r <= {CNT_W{1'b0}};
        count_direction_flag_r <= 1'b0;
        period_buf_r <= `MPWM_RST_PER;
        period_value_r <= `MPWM_RST_PER;
        pair_mode_r <= `MPWM_RST_OC1; // RULE22
        update_disable_bit_r <= 1'b0;
        immediate_update_bit_r <= 1'b0;
        pre_cnt_r <= 6'h00; // RULE6
        post_cnt_r <= 4'h0; // RULE8
        timebase_event_o <= 1'b0;
    end
    else
    begin
        wr_pend_r <= addr_phase && hwrite_i;
        wr_addr_r <= addr_phase ? haddr_i[7:0] : wr_addr_r;
        timebase_event_o <= post_hit || direct_evt; // RULE26

        if (wr_cnt || wr_ctrl)
            pre_cnt_r <= 6'h00; // RULE6
        else if (timebase_enable_bit_r)
            pre_cnt_r <= tick ? 6'h00 : pre_cnt_r + 6'h01;

        if (wr_cnt || wr_ctrl)
            post_cnt_r <= 4'h0; // RULE8
        else if (post_hit)
            post_cnt_r <= 4'h0;
        else if (raw_post_evt)
            post_cnt_r <= post_cnt_r + 4'h1;

        if (per_load)
            period_value_r <= period_buf_r;
        if (wr_per)
            period_buf_r <= hwdata_i[CNT_W-1:0];
        if (wr_oc1)
            pair_mode_r <= hwdata_i[`MPWM_OC1_PMOD_LO+NUM_PAIRS-1:
                                    `MPWM_OC1_PMOD_LO];
        if (wr_oc2)
        begin
            update_disable_bit_r <= hwdata_i[`MPWM_OC2_UPDATE_DISABLE_BIT];
            immediate_update_bit_r <= hwdata_i[`MPWM_OC2_IUE];
        end

        // The counter is only touched by its own write, never by control.
        if (wr_cnt)
            timebase_counter_r <= hwdata_i[CNT_W-1:0];
        else if (run)
        begin
            if (!updn)
            begin
                if (at_per)
                    timebase_counter_r <= {CNT_W{1'b0}}; // RULE23
                else
                    timebase_counter_r <= timebase_counter_r + 1'b1;
            end
            else if (!count_direction_flag_r)
            begin
                if (at_per)
                begin
                    count_direction_flag_r <= 1'b1; // RULE1
                    timebase_counter_r <= timebase_counter_r - 1'b1;
                end
                else
                    timebase_counter_r <= timebase_counter_r + 1'b1;
            end
            else
            begin
                if (at_zero)
                begin
                    count_direction_flag_r <= 1'b0;
                    timebase_counter_r <= timebase_counter_r + 1'b1;
                end
                else
                    timebase_counter_r <= timebase_counter_r - 1'b1;
            end
        end

        if (wr_ctrl)
        begin
            timebase_enable_bit_r <= hwdata_i[`MPWM_CTRL_EN];
            event_postscale_select_r <=
                hwdata_i[`MPWM_CTRL_OPS_HI:`MPWM_CTRL_OPS_LO];
            input_prescale_select_r <=
                hwdata_i[`MPWM_CTRL_CKPS_HI:`MPWM_CTRL_CKPS_LO];
            timebase_mode_field_r <=
                hwdata_i[`MPWM_CTRL_MOD_HI:`MPWM_CTRL_MOD_LO];
        end
        else if (per_match
                 && timebase_mode_field_r == `MPWM_MODE_SINGLE)
            timebase_enable_bit_r <= 1'b0; // RULE23
    end
end

// =====================================================================
// Duty comparators, one per output pair.
// The duty is compared at half-step scale: the counter is doubled and
// bit zero of the duty gives an odd duty the same edge as the next even duty.
wire [DUTY_W-1:0] cnt2 = {timebase_counter_r, 1'b0};
wire [DUTY_W-1:0] per2 = {period_value_r, 1'b0};
genvar gi;
generate
    for (gi = 0; gi < NUM_PAIRS; gi = gi + 1)
    begin : g_pair
        wire duty_wr = wr_pend_r
            && (wr_addr_r == `MPWM_OFF_DUTY1 + 8'h04 * gi);
        wire [DUTY_W-1:0] da = duty_act_r[gi];
        reg cmp_nxt;
        always @*
        begin
            cmp_nxt = cmp_r[gi];
            if (da == {DUTY_W{1'b0}})
                cmp_nxt = 1'b0; // RULE12 RULE14
            else if (!updn)
            begin
                if (da > per2)
                    cmp_nxt = 1'b1; // RULE12
                else
                    cmp_nxt = (cnt2 < da); // RULE11 RULE15 RULE20
            end
            else
            begin
                if (da >= per2)
                    cmp_nxt = 1'b1; // RULE14
                else
                    cmp_nxt = (cnt2 < da); // RULE13 RULE15
            end
        end

        always @(posedge clk_sys_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                duty_buf_r[gi] <= `MPWM_RST_DUTY;
                duty_act_r[gi] <= `MPWM_RST_DUTY;
                cmp_r[gi] <= 1'b0;
                pair_high_output_o[gi] <= 1'b0;
                pair_low_output_o[gi] <= 1'b1;
                pair_mode_bit_o[gi] <= 1'b0;
            end
            else
            begin
                if (duty_wr)
                    duty_buf_r[gi] <= hwdata_i[DUTY_W-1:0]; // RULE16
                if (duty_wr && immediate_update_bit_r)
                    duty_act_r[gi] <= hwdata_i[DUTY_W-1:0]; // RULE19
                else if (duty_load)
                    duty_act_r[gi] <= duty_buf_r[gi]; // RULE16
                cmp_r[gi] <= cmp_nxt;
                pair_high_output_o[gi] <= cmp_nxt; // RULE21
                pair_low_output_o[gi] <= !cmp_nxt; // RULE21
                pair_mode_bit_o[gi] <= pair_mode_r[gi]; // RULE22
            end
        end
    end
endgenerate

// =====================================================================
// Read data, registered in the address phase.
reg [31:0] rd_nxt;
integer ri;
always @*
begin
    rd_nxt = 32'h0000_0000;
    case (haddr_i[7:0])
        `MPWM_OFF_CTRL:
        begin
            rd_nxt[`MPWM_CTRL_EN] = timebase_enable_bit_r;
            rd_nxt[`MPWM_CTRL_OPS_HI:`MPWM_CTRL_OPS_LO] =
                event_postscale_select_r;
            rd_nxt[`MPWM_CTRL_CKPS_HI:`MPWM_CTRL_CKPS_LO] =
                input_prescale_select_r;
            rd_nxt[`MPWM_CTRL_MOD_HI:`MPWM_CTRL_MOD_LO] =
                timebase_mode_field_r;
        end
        `MPWM_OFF_CNT:
        begin
            rd_nxt[CNT_W-1:0] = timebase_counter_r;
            rd_nxt[`MPWM_CNT_DIR] = count_direction_flag_r; // RULE24
        end
        `MPWM_OFF_PER: rd_nxt[CNT_W-1:0] = period_buf_r;
        `MPWM_OFF_OC1: rd_nxt[NUM_PAIRS-1:0] = pair_mode_r;
        `MPWM_OFF_OC2:
        begin
            rd_nxt[`MPWM_OC2_UPDATE_DISABLE_BIT] = update_disable_bit_r;
            rd_nxt[`MPWM_OC2_IUE] = immediate_update_bit_r;
        end
        default:
        begin
            for (ri = 0; ri < NUM_PAIRS; ri = ri + 1)
                if (haddr_i[7:0] == `MPWM_OFF_DUTY1 + 8'h04 * ri)
                    rd_nxt[DUTY_W-1:0] = duty_buf_r[ri];
        end
    endcase
end

always @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        hrdata_o <= 32'h0000_0000;
        hreadyout_o <= 1'b1;
        hresp_o <= 1'b0;
    end
    else
    begin
        hreadyout_o <= 1'b1;
        hresp_o <= 1'b0;
        if (addr_phase && !hwrite_i)
            hrdata_o <= rd_nxt;
    end
end

endmodule // mpwm_core

// *** tb/mpwm_gate_drv.sv ***
// Gate-driver model of the motor bridge legs fed by the PWM pairs.
module mpwm_gate_drv (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [3:0] gate_hi_i,
    input wire [3:0] gate_lo_i,
    output logic shoot_o
);
timeunit 1ns;
timeprecision 1ns;
// =====
// One cycle of overlap destroys a real leg, so the flag sticks.
always_ff @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
        shoot_o <= 1'b0;
    else if ((gate_hi_i & gate_lo_i) != 4'h0)
        shoot_o <= 1'b1;
end
endmodule // mpwm_gate_drv

// *** tb/mpwm_core_sva.sv ***
// Port-level assertions for the motor PWM core.
`include "mpwm_regs.vh"
module mpwm_core_chk #(
    parameter NUM_PAIRS = 4
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [NUM_PAIRS-1:0] pair_high_output_o,
    input wire [NUM_PAIRS-1:0] pair_low_output_o,
    input wire [NUM_PAIRS-1:0] pair_mode_bit_o,
    input wire timebase_event_o
);
timeunit 1ns;
timeprecision 1ns;
logic ap_q;
logic aw_q;
logic [7:0] aa_q;
logic [NUM_PAIRS-1:0] pmd_q;
wire wr_pm = ap_q & aw_q & (aa_q == `MPWM_OFF_OC1);
wire rd_pm = ap_q & ~aw_q & (aa_q == `MPWM_OFF_OC1);
wire rd_un = ap_q & ~aw_q & (aa_q > `MPWM_OFF_DUTY4);
// =====
// Data-phase tracker: a flag is true while its transfer's data stand.
always_ff @(posedge clk_sys_i or negedge rst_n_i)
begin
    if (!rst_n_i)
        ap_q <= 1'b0;
    else
        ap_q <= hsel_i & hready_i & htrans_i[1];
end
always_ff @(posedge clk_sys_i)
begin
    aw_q <= hwrite_i;
    aa_q <= haddr_i[7:0];
    if (wr_pm)
        pmd_q <= hwdata_i[NUM_PAIRS-1:0];
end
// =====
// Properties
default clocking cb @(posedge clk_sys_i);
endclocking
default disable iff (!rst_n_i);
property p_compl;
    ((pair_high_output_o ^ pair_low_output_o) | pair_mode_bit_o) == '1;
endproperty
a_compl: assert property (p_compl)
    else $error("low output is not the complement of high");
property p_ready;
    hreadyout_o == 1'b1;
endproperty
a_ready: assert property (p_ready)
    else $error("wait state inserted");
property p_okay;
    hresp_o == 1'b0;
endproperty
a_okay: assert property (p_okay)
    else $error("response not okay");
property p_pulse;
    timebase_event_o |=> !timebase_event_o;
endproperty
a_pulse: assert property (p_pulse)
    else $error("event longer than one cycle");
property p_pm_wr;
    wr_pm |=> ##[0:1] (pair_mode_bit_o == pmd_q);
endproperty
a_pm_wr: assert property (p_pm_wr)
    else $error("pair mode write not applied");
property p_pm_hold;
    $changed(pair_mode_bit_o) |-> ($past(wr_pm) || $past(wr_pm, 2));
endproperty
a_pm_hold: assert property (p_pm_hold)
    else $error("pair mode changed without a write");
property p_rd_pm;
    rd_pm |-> hrdata_o == {{(32-NUM_PAIRS){1'b0}}, pair_mode_bit_o};
endproperty
a_rd_pm: assert property (p_rd_pm)
    else $error("pair mode read mismatch");
property p_rd_un;
    rd_un |-> hrdata_o == 32'h0;
endproperty
a_rd_un: assert property (p_rd_un)
    else $error("unmapped read not zero");
endmodule // mpwm_core_chk

bind mpwm_core mpwm_core_chk #(.NUM_PAIRS(NUM_PAIRS)) u_chk (
    .clk_sys_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .pair_high_output_o, .pair_low_output_o, .pair_mode_bit_o,
    .timebase_event_o
);

// *** tb/mpwm_core_tb_top.sv ***
// Directed bench for the motor PWM core over its AHB-Lite port.
`include "mpwm_regs.vh"
module mpwm_core_tb_top;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys_i = 1'b0;
logic rst_n_i = 1'b0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
wire [31:0] hrdata;
wire hready;
wire hresp;
wire [3:0] p_hi;
wire [3:0] p_lo;
wire [3:0] p_md;
wire ev;
wire shoot;
int n_fail = 0;
int n_compared = 0;
int cyc = 0;
int g;
logic [3:0] hor;
logic [3:0] hand;
logic [31:0] q;
logic dor;
logic dand;
mpwm_core dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .pair_high_output_o(p_hi), .pair_low_output_o(p_lo),
    .pair_mode_bit_o(p_md), .timebase_event_o(ev)
);
mpwm_gate_drv u_drv (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .gate_hi_i(p_hi),
    .gate_lo_i(p_lo), .shoot_o(shoot)
);
initial
    forever #50 clk_sys_i = ~clk_sys_i;
// =====
// Tasks
task test_done;
    $display("TB: fails %0d compared %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
        n_fail++;
        $display("Error t=%0t seen %h want %h", $time, s, e);
    end
endtask
// Each transfer starts one edge after the last ends, so no signal is
// assigned twice in one time step.
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    q = hrdata;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
endtask
task cfg(input logic en, input logic [3:0] ops, input logic [1:0] ps,
    input logic [1:0] md);
    wr(`MPWM_OFF_CTRL, {16'h0, en, 7'h0, ops, ps, md});
endtask
task start(input logic [14:0] p, input logic [3:0] ops,
    input logic [1:0] ps, input logic [1:0] md);
    cfg(1'b0, ops, ps, md);
    wr(`MPWM_OFF_CNT, 32'h0);
    wr(`MPWM_OFF_PER, {17'h0, p});
    cfg(1'b1, ops, ps, md);
endtask
task gap;
    @(negedge clk_sys_i);
    while (ev !== 1'b1) @(negedge clk_sys_i);
    g = 0;
    hor = 4'h0;
    hand = 4'hF;
    do
    begin
        @(negedge clk_sys_i);
        g++;
        hor = hor | p_hi;
        hand = hand & p_hi;
    end
    while (ev !== 1'b1);
endtask
task run(input logic [14:0] p, input logic [3:0] ops,
    input logic [1:0] ps, input logic [1:0] md, input int e);
    start(p, ops, ps, md);
    gap;
    chk(g, e);
endtask
task quiet(input int n);
    g = 0;
    repeat (n)
    begin
        @(negedge clk_sys_i);
        g += (ev === 1'b1);
    end
endtask
// =====
// Sequence
initial
begin
    repeat (15) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({p_hi, p_lo, p_md, ev}, {4'h0, 4'hF, 4'h0, 1'b0});
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`MPWM_OFF_OC1, 32'h0);
    rd(8'h40, 32'h0);
    wr(`MPWM_OFF_OC1, 32'h5);
    rd(`MPWM_OFF_OC1, 32'h5);
    wr(`MPWM_OFF_OC1, 32'h0);
    wr(`MPWM_OFF_PER, 32'hFFFF);
    rd(`MPWM_OFF_PER, 32'h7FFF);
    wr(`MPWM_OFF_CNT, 32'h5);
    cfg(1'b0, 4'h0, 2'h0, `MPWM_MODE_FREE);
    rd(`MPWM_OFF_CNT, 32'h5);
    wr(`MPWM_OFF_DUTY1, 32'h0);
    wr(`MPWM_OFF_DUTY2, 32'hFFFF);
    wr(`MPWM_OFF_DUTY3, 32'h8);
    wr(`MPWM_OFF_DUTY4, 32'h4);
    // Period 1 is never programmed: it would flood the event line.
    run(15'd9, 4'h0, 2'h0, `MPWM_MODE_FREE, 10);
    chk({hor[0], hand[1]}, 2'b01);
    chk({hor[2], hand[2]}, 2'b10);
    for (int i = 0; i < 4; i++)
        run(15'd3, {3'h0, i == 1}, i[1:0], `MPWM_MODE_FREE,
            (4 << (2 * i)) << (i == 1));
    run(15'd4, 4'h0, 2'h0, `MPWM_MODE_UPDN, 8);
    chk({hor[0], hor[2], hand[2]}, 3'b011);
    chk({hor[3], hand[3]}, 2'b10);
    dor = 1'b0;
    dand = 1'b1;
    repeat (8)
    begin
        bus(1'b0, `MPWM_OFF_CNT, 32'h0);
        dor = dor | q[15];
        dand = dand & q[15];
    end
    chk({dor, dand}, 2'b10);
    run(15'd4, 4'h1, 2'h0, `MPWM_MODE_UPDN, 16);
    run(15'd4, 4'h5, 2'h0, `MPWM_MODE_DBL, 4);
    start(15'd0, 4'h0, 2'h0, `MPWM_MODE_FREE);
    quiet(40);
    chk(g, 0);
    start(15'd3, 4'h0, 2'h0, `MPWM_MODE_SINGLE);
    quiet(30);
    chk(g, 1);
    rd(`MPWM_OFF_CTRL, 32'h1);
    wr(`MPWM_OFF_DUTY1, 32'hFFFF);
    start(15'd200, 4'h0, 2'h0, `MPWM_MODE_FREE);
    quiet(10);
    chk(p_hi[0], 1'b1);
    wr(`MPWM_OFF_DUTY1, 32'h0);
    quiet(4);
    chk(p_hi[0], 1'b1);
    wr(`MPWM_OFF_OC2, 32'h4);
    wr(`MPWM_OFF_DUTY1, 32'h0);
    quiet(4);
    chk(p_hi[0], 1'b0);
    wr(`MPWM_OFF_DUTY1, 32'hFFFF);
    quiet(4);
    chk(p_hi[0], 1'b1);
    chk(shoot, 1'b0);
    test_done;
end
always @(posedge clk_sys_i)
begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
        n_fail++;
        test_done;
    end
end
endmodule // mpwm_core_tb_top
